/* inc/fdp_pkg.sv */
/*
 * Shared constants for the flash download and programming controller.
 * Assumes one 10 MHz system clock and a 24-bit CPU address space.
 */
package fdp_pkg;
    // ------------------------------------------------------------
    // Key codes
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_DOWNLOAD = 8'ha5;
    localparam logic [7:0] KEY_PROGRAM = 8'h5a;
    localparam logic [7:0] KEY_RESET = 8'h00;
    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam logic [23:0] USER_TOP = 24'h008000;
    localparam logic [23:0] RAM_BASE = 24'hff0000;
    localparam logic [23:0] ENTRY_PROG_OFS = 24'h000010;
    localparam logic [23:0] ENTRY_INIT_OFS = 24'h000020;
    localparam logic [23:0] COPY_OFS = 24'h000001;
    localparam int DEST_SHIFT = 11;
    localparam logic [7:0] DEST_MAX = 8'h04;
    localparam logic [7:0] DEST_RESET = 8'h00;
    // ------------------------------------------------------------
    // Programming unit
    // ------------------------------------------------------------
    localparam int BLOCK_SHIFT = 7;
    localparam logic [6:0] BLOCK_LAST = 7'h7f;
    localparam logic [6:0] ALIGN_MASK = 7'h7f;
    localparam logic [7:0] FILLER = 8'hff;
    localparam logic [2:0] PROG_HOLD = 3'h3;
    // ------------------------------------------------------------
    // Frequency window in MHz
    // ------------------------------------------------------------
    localparam logic [7:0] FREQ_MIN = 8'h08;
    localparam logic [7:0] FREQ_MAX = 8'h30;
    // ------------------------------------------------------------
    // Result codes and flag positions
    // ------------------------------------------------------------
    localparam logic [7:0] RESULT_OK = 8'h00;
    localparam int DL_SEL_BIT = 0;
    localparam int DL_KEY_BIT = 1;
    localparam int OP_ADDR_BIT = 0;
    localparam int OP_SRC_BIT = 1;
    localparam int OP_OVER_BIT = 2;
    localparam int OP_KEY_BIT = 3;
    localparam int OP_PROT_BIT = 4;
    localparam int OP_FREQ_BIT = 5;

    typedef enum logic [2:0] {
        ST_IDLE, ST_MAP, ST_CHECK, ST_COPY, ST_RESULT, ST_UNMAP, ST_PROG
    } fdp_state_type;
endpackage

/* hw/fdp_blank_map.sv */
/*
 * One flag per 128-byte unit of the user array, set once programmed.
 * Assumes the caller marks a unit only after it has been fully written.
 */
`timescale 1ns/1ns
module fdp_blank_map #(
    parameter int BLOCKS = 256,
    parameter int IDX_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_mark,
    input wire logic [IDX_W-1:0] i_idx,
    output logic o_programmed
);
    logic [BLOCKS-1:0] done_r;

    // ------------------------------------------------------------
    // Per-unit flags
    // ------------------------------------------------------------
    for (genvar g = 0; g < BLOCKS; g++) begin : g_unit
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                done_r[g] <= 1'b0;
            end else if (i_mark && i_idx == IDX_W'(g)) begin
                done_r[g] <= 1'b1;
            end
        end
    end

    assign o_programmed = done_r[i_idx];
endmodule

/* hw/fdp_ctrl.sv */
/*
 * Flash download and programming controller: key gate, routine download
 * into on-chip RAM, initialisation check and 128-byte programming unit.
 * Assumes CPU-side bits arrive as synchronous one-cycle write strobes.
 */
`timescale 1ns/1ns
// Behaviour
// R01: Each programming operation writes exactly 128 bytes; code steps 128 bytes but strobes o_flash_wr only for the non-0xFF ones
// R02: Software pads short blocks, 0xFF preferred
// R03: Multiple routine selections report a selection error
// R04: Download request needs key 0xA5
// R05: Request needs emulation off, key, RAM execution
// R06: Request bit starts download, reads zero after
// R07: Software clears vector base, reads status twice
// R08: Map routine store, check, copy, unmap
// R09: Completion clears selections, request; writes result
// R10: Interrupts held during download, released afterwards
// R11: CPU general registers preserved across download
// R12: Result 0x00 success, flags name cause
// R13: Bad RAM destination sets flag, result untouched
// R14: Frequency outside 8 to 48 MHz rejected
// R15: Software sets branch address zero when unused
// R16: Initialisation entry 32 bytes above start
// R17: Programming entry 16 bytes above start
// R18: Foreign bus master during programming enters protection
// R19: Programming needs key 0x5A
// R20: Destination inside array, 128-byte aligned
// R21: Source data in flash is refused
// R22: Reprogramming a programmed unit is an error
// R23: Other key values disable download and programming
module fdp_ctrl
    import fdp_pkg::*;
#(
    parameter int COPY_LEN = 64,
    parameter int BLOCKS = 256,
    parameter int IDX_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_key_wr,
    input wire logic [7:0] i_key_data,
    input wire logic i_sel_wr,
    input wire logic i_prog_sel,
    input wire logic i_erase_sel,
    input wire logic i_dest_wr,
    input wire logic [7:0] i_dest_data,
    input wire logic i_req_wr,
    input wire logic i_req_data,
    input wire logic i_exec_in_ram,
    input wire logic i_ram_emul_on,
    input wire logic [7:0] i_rom_data,
    input wire logic i_init_start,
    input wire logic [7:0] i_op_frequency,
    input wire logic i_prog_start,
    input wire logic [fdp_pkg::ADDR_W-1:0] i_target_addr,
    input wire logic [fdp_pkg::ADDR_W-1:0] i_source_addr,
    input wire logic [7:0] i_src_data,
    input wire logic i_bus_other_master,
    input wire logic [3:0] i_irq,
    input wire logic [3:0] i_irq_edge,
    output logic [7:0] o_flash_key,
    output logic o_prog_sel,
    output logic o_erase_sel,
    output logic [7:0] o_dest,
    output logic o_dest_error,
    output logic o_download_request,
    output logic o_dl_busy,
    output logic o_map_routine,
    output logic o_cpu_hold,
    output logic [fdp_pkg::ADDR_W-1:0] o_rom_addr,
    output logic o_ram_wr,
    output logic [fdp_pkg::ADDR_W-1:0] o_ram_addr,
    output logic [7:0] o_ram_data,
    output logic [fdp_pkg::ADDR_W-1:0] o_init_entry,
    output logic [fdp_pkg::ADDR_W-1:0] o_prog_entry,
    output logic o_op_done,
    output logic [7:0] o_op_result,
    output logic o_prog_busy,
    output logic o_flash_wr,
    output logic [fdp_pkg::ADDR_W-1:0] o_flash_addr,
    output logic [7:0] o_flash_data,
    output logic [fdp_pkg::ADDR_W-1:0] o_src_addr,
    output logic o_protect,
    output logic [3:0] o_irq
);
    import fdp_pkg::*;

    fdp_state_type state_r;
    logic [7:0] copy_cnt_r;
    logic [6:0] byte_cnt_r;
    logic [2:0] hold_r;
    logic [ADDR_W-1:0] dl_start;
    logic [ADDR_W-1:0] tgt_base_r;
    logic [3:0] irq_prev_r;
    logic [3:0] irq_pend_r;
    logic [7:0] dl_result;
    logic [7:0] prog_err;
    logic idle;
    logic req_ok;
    logic dest_bad;
    logic freq_bad;
    logic unit_done;
    logic mark;

    assign idle = (state_r == ST_IDLE);
    // R04 R05 R23: only key 0xA5 with emulation off and RAM execution
    assign req_ok = idle && i_req_wr && i_req_data && o_flash_key == KEY_DOWNLOAD  // [R04] [R23]
                    && !i_ram_emul_on && i_exec_in_ram;  // [R05]
    assign dest_bad = (o_dest > DEST_MAX);
    assign dl_start = RAM_BASE + (ADDR_W'(o_dest[2:0]) << DEST_SHIFT);
    assign freq_bad = (i_op_frequency < FREQ_MIN) || (i_op_frequency > FREQ_MAX);  // [R14]
    assign mark = (state_r == ST_PROG) && hold_r == 3'h0 && byte_cnt_r == BLOCK_LAST
                  && !i_bus_other_master && i_src_data == FILLER
                  || (state_r == ST_PROG) && hold_r == 3'h1 && byte_cnt_r == BLOCK_LAST
                  && !i_bus_other_master;

    always_comb begin
        dl_result = RESULT_OK;
        dl_result[DL_SEL_BIT] = (o_prog_sel == o_erase_sel);  // [R03]
        dl_result[DL_KEY_BIT] = (o_flash_key != KEY_DOWNLOAD);
        prog_err = RESULT_OK;
        prog_err[OP_KEY_BIT] = (o_flash_key != KEY_PROGRAM);  // [R19] [R23]
        prog_err[OP_ADDR_BIT] = (i_target_addr >= USER_TOP)
                                || ((i_target_addr[6:0] & ALIGN_MASK) != 7'h00);  // [R20]
        prog_err[OP_SRC_BIT] = (i_source_addr < USER_TOP);  // [R21]
        prog_err[OP_OVER_BIT] = unit_done;  // [R22]
        prog_err[OP_PROT_BIT] = o_protect;
    end

    fdp_blank_map #(
        .BLOCKS(BLOCKS),
        .IDX_W(IDX_W)
    ) u_map (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_mark(mark),
        .i_idx(state_r == ST_PROG ? tgt_base_r[BLOCK_SHIFT +: IDX_W]
                                  : i_target_addr[BLOCK_SHIFT +: IDX_W]),
        .o_programmed(unit_done)
    );

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flash_key <= KEY_RESET;
            o_dest <= DEST_RESET;
        end else if (idle) begin
            if (i_key_wr) begin
                o_flash_key <= i_key_data;
            end
            if (i_dest_wr) begin
                o_dest <= i_dest_data;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prog_sel <= 1'b0;
            o_erase_sel <= 1'b0;
        end else if (state_r == ST_UNMAP) begin
            o_prog_sel <= 1'b0;  // [R09]
            o_erase_sel <= 1'b0;  // [R09]
        end else if (idle && i_sel_wr) begin
            o_prog_sel <= i_prog_sel;  // [R03]
            o_erase_sel <= i_erase_sel;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dest_error <= 1'b0;
        end else if (state_r == ST_CHECK && dest_bad) begin
            o_dest_error <= 1'b1;  // [R13]
        end else if (idle && i_dest_wr) begin
            o_dest_error <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            copy_cnt_r <= 8'h00;
            byte_cnt_r <= 7'h00;
            hold_r <= 3'h0;
            tgt_base_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    copy_cnt_r <= 8'h00;
                    byte_cnt_r <= 7'h00;
                    hold_r <= 3'h0;
                    if (req_ok) begin
                        state_r <= ST_MAP;  // [R06]
                    end else if (i_prog_start && prog_err == RESULT_OK) begin
                        state_r <= ST_PROG;
                        tgt_base_r <= i_target_addr;
                    end
                end
                ST_MAP: begin
                    state_r <= ST_CHECK;  // [R08]
                end
                ST_CHECK: begin
                    if (dest_bad) begin
                        state_r <= ST_UNMAP;  // [R13]
                    end else if (dl_result != RESULT_OK) begin
                        state_r <= ST_RESULT;
                    end else begin
                        state_r <= ST_COPY;
                    end
                end
                ST_COPY: begin
                    copy_cnt_r <= copy_cnt_r + 8'h01;
                    if (copy_cnt_r == 8'(COPY_LEN - 1)) begin
                        state_r <= ST_RESULT;
                    end
                end
                ST_RESULT: begin
                    state_r <= ST_UNMAP;  // [R09]
                end
                ST_UNMAP: begin
                    state_r <= ST_IDLE;  // [R08]
                end
                ST_PROG: begin
                    if (i_bus_other_master) begin
                        state_r <= ST_IDLE;  // [R18]
                    end else if (hold_r == 3'h0 && i_src_data != FILLER) begin
                        hold_r <= PROG_HOLD;
                    end else if (hold_r == 3'h0 || hold_r == 3'h1) begin
                        // Filler bytes skip the write hold [R02]
                        hold_r <= 3'h0;
                        byte_cnt_r <= byte_cnt_r + 7'h01;
                        if (byte_cnt_r == BLOCK_LAST) begin
                            state_r <= ST_IDLE;  // [R01]
                        end
                    end else begin
                        hold_r <= hold_r - 3'h1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Download status and RAM writes
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_download_request <= 1'b0;
            o_dl_busy <= 1'b0;
            o_map_routine <= 1'b0;
            o_cpu_hold <= 1'b0;
        end else begin
            o_download_request <= req_ok || (o_download_request && state_r != ST_UNMAP);  // [R06]
            o_dl_busy <= req_ok || (o_dl_busy && state_r != ST_UNMAP);
            o_map_routine <= req_ok || (o_map_routine && state_r != ST_UNMAP);  // [R08]
            // CPU stalled so its general registers are untouched [R11]
            o_cpu_hold <= req_ok || (o_cpu_hold && state_r != ST_UNMAP);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ram_wr <= 1'b0;
            o_ram_addr <= '0;
            o_ram_data <= 8'h00;
            o_rom_addr <= '0;
        end else begin
            o_ram_wr <= (state_r == ST_COPY) || (state_r == ST_RESULT);
            o_rom_addr <= ADDR_W'(copy_cnt_r) + ADDR_W'(8'h01);
            if (state_r == ST_COPY) begin
                o_ram_addr <= dl_start + COPY_OFS + ADDR_W'(copy_cnt_r);  // [R08]
                o_ram_data <= i_rom_data;
            end else if (state_r == ST_RESULT) begin
                o_ram_addr <= dl_start;
                o_ram_data <= dl_result;  // [R09] [R12]
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_init_entry <= '0;
            o_prog_entry <= '0;
        end else if (state_r == ST_RESULT) begin
            o_init_entry <= dl_start + ENTRY_INIT_OFS;  // [R16]
            o_prog_entry <= dl_start + ENTRY_PROG_OFS;  // [R17]
        end
    end

    // ------------------------------------------------------------
    // Initialisation and programming results
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_op_done <= 1'b0;
            o_op_result <= RESULT_OK;
        end else begin
            o_op_done <= 1'b0;
            if (idle && !req_ok && i_init_start) begin
                o_op_done <= 1'b1;
                o_op_result <= freq_bad ? (8'h01 << OP_FREQ_BIT) : RESULT_OK;  // [R14]
            end else if (idle && !req_ok && i_prog_start && prog_err != RESULT_OK) begin
                o_op_done <= 1'b1;
                o_op_result <= prog_err;  // [R20] [R21] [R22]
            end else if (state_r == ST_PROG && i_bus_other_master) begin
                o_op_done <= 1'b1;
                o_op_result <= 8'h01 << OP_PROT_BIT;  // [R18]
            end else if (mark) begin
                o_op_done <= 1'b1;
                o_op_result <= RESULT_OK;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_protect <= 1'b0;
        end else if (state_r == ST_PROG && i_bus_other_master) begin
            o_protect <= 1'b1;  // [R18]
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prog_busy <= 1'b0;
            o_flash_wr <= 1'b0;
            o_flash_addr <= '0;
            o_flash_data <= 8'h00;
            o_src_addr <= '0;
        end else begin
            o_prog_busy <= (state_r == ST_PROG) && !i_bus_other_master && !mark
                           || idle && !req_ok && i_prog_start && prog_err == RESULT_OK;
            o_flash_wr <= (state_r == ST_PROG) && !i_bus_other_master
                          && hold_r == 3'h0 && i_src_data != FILLER;
            if (idle) begin
                o_src_addr <= i_source_addr;
            end else if (state_r == ST_PROG && hold_r == 3'h0) begin
                o_flash_addr <= tgt_base_r + ADDR_W'(byte_cnt_r);  // [R01]
                o_flash_data <= i_src_data;
            end
            if (state_r == ST_PROG && (hold_r == 3'h1
                || hold_r == 3'h0 && i_src_data == FILLER)) begin
                o_src_addr <= o_src_addr + ADDR_W'(8'h01);
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt hold during download
    // ------------------------------------------------------------
    for (genvar g = 0; g < 4; g++) begin : g_irq
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                irq_prev_r[g] <= 1'b0;
                irq_pend_r[g] <= 1'b0;
                o_irq[g] <= 1'b0;
            end else begin
                irq_prev_r[g] <= i_irq[g];
                if (o_dl_busy) begin
                    // Edge requests latched, levels must persist [R10]
                    irq_pend_r[g] <= irq_pend_r[g] | (i_irq_edge[g] & i_irq[g] & ~irq_prev_r[g]);
                    o_irq[g] <= 1'b0;
                end else begin
                    irq_pend_r[g] <= 1'b0;
                    o_irq[g] <= i_irq_edge[g] ? (irq_pend_r[g] | (i_irq[g] & ~irq_prev_r[g]))
                                              : i_irq[g];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_dl_start;
        req_ok;
    endsequence

    sequence s_mapped;
        o_map_routine && o_cpu_hold;
    endsequence

    a_key_gate_dl: assert property (@(posedge i_clk) disable iff (i_rst)  // [R04]
        (idle && i_req_wr && i_req_data && o_flash_key != KEY_DOWNLOAD && !o_dl_busy)
        |=> !o_dl_busy)
        else $error("download started without key");
    a_req_cond: assert property (@(posedge i_clk) disable iff (i_rst)  // [R05]
        (idle && i_req_wr && (i_ram_emul_on || !i_exec_in_ram) && !o_dl_busy) |=> !o_dl_busy)
        else $error("download started outside allowed conditions");
    a_dl_map_seq: assert property (@(posedge i_clk) disable iff (i_rst)  // [R08]
        s_dl_start |=> s_mapped [*3])
        else $error("routine store not mapped during download");
    a_dl_clear: assert property (@(posedge i_clk) disable iff (i_rst)  // [R09]
        (state_r == ST_UNMAP) |=> !o_prog_sel && !o_erase_sel && !o_download_request)
        else $error("selections not cleared after download");
    a_irq_hold: assert property (@(posedge i_clk) disable iff (i_rst)  // [R10]
        o_dl_busy |=> (o_irq == 4'h0))
        else $error("interrupt raised during download");
    a_dest_err: assert property (@(posedge i_clk) disable iff (i_rst)  // [R13]
        (state_r == ST_CHECK && dest_bad) |=> o_dest_error && !o_ram_wr ##1 !o_ram_wr)
        else $error("result written despite bad destination");
    a_freq_range: assert property (@(posedge i_clk) disable iff (i_rst)  // [R14]
        (idle && !req_ok && i_init_start && freq_bad) |=> o_op_done && o_op_result[OP_FREQ_BIT])
        else $error("bad frequency accepted");
    a_prog_key: assert property (@(posedge i_clk) disable iff (i_rst)  // [R19]
        (idle && !req_ok && i_prog_start && o_flash_key != KEY_PROGRAM)
        |=> o_op_done && !o_prog_busy ##1 !o_flash_wr)
        else $error("programming without key");
    a_protect_dma: assert property (@(posedge i_clk) disable iff (i_rst)  // [R18]
        (state_r == ST_PROG && i_bus_other_master) |=> o_protect && !o_prog_busy)
        else $error("foreign master did not protect");
    a_prog_align: assert property (@(posedge i_clk) disable iff (i_rst)  // [R20]
        (state_r == ST_PROG) |-> (tgt_base_r[6:0] == 7'h00) && (tgt_base_r < USER_TOP))
        else $error("misaligned programming destination");
endmodule

/* verif/fdp_sw_model.sv */
/*
 * Software-side model: routine store, RAM result byte, program source data.
 * Assumes same-cycle reads and one-cycle write pulses from the controller.
 */
`timescale 1ns/1ns
module fdp_sw_model (
    input wire logic i_clk,
    input wire logic [23:0] i_rom_addr,
    input wire logic [23:0] i_src_addr,
    input wire logic i_ram_wr,
    input wire logic [23:0] i_ram_addr,
    input wire logic [7:0] i_ram_data,
    input wire logic i_flash_wr,
    output logic [7:0] o_rom_data,
    output logic [7:0] o_src_data,
    output logic [7:0] o_result,
    output int o_writes
);
    // Odd bytes of each unit are filler
    assign o_src_data = i_src_addr[0] ? 8'hff : i_src_addr[7:0];
    assign o_rom_data = i_rom_addr[7:0] ^ 8'h3c;
    initial o_result = 8'hff;
    initial o_writes = 0;
    always @(posedge i_clk) begin
        if (i_ram_wr && i_ram_addr[10:0] == 11'h000) o_result <= i_ram_data;
        if (i_flash_wr) o_writes <= o_writes + 1;
    end
endmodule

/* verif/test_fdp_ctrl.sv */
/*
 * Self-checking bench for the flash download and programming controller.
 * Assumes the software model on the far side and a 10 MHz clock.
 */
`timescale 1ns/1ns
module test_fdp_ctrl;
    import fdp_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic ps = 1'b0, es = 1'b0, ex = 1'b1, em = 1'b0, bm = 1'b0;
    logic psel, esel, derr, dreq, busy, done, mw, fw, prot;
    logic [5:0] st = 6'h00;
    logic [7:0] kd = 8'h00, dd = 8'h00, fq = 8'h00, rd, sd, md, ores, res, d;
    logic [23:0] ta = 24'h000000, sa = 24'h000000, ra, ma, ie, pe, so;
    logic [7:0] fqs[5] = '{8'd7, 8'd8, 8'd48, 8'd49, 8'd20};
    logic [7:0] expq[$];
    logic [3:0] irq = 4'h0, oirq;
    int num_errors = 0, checked = 0, cyc = 0, wr, wr0, i;
    always #50 i_clk = ~i_clk;
    fdp_ctrl #(.COPY_LEN(4)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_key_wr(st[0]),
        .i_key_data(kd), .i_sel_wr(st[1]), .i_prog_sel(ps), .i_erase_sel(es),
        .i_dest_wr(st[2]), .i_dest_data(dd), .i_req_wr(st[3]), .i_req_data(st[3]),
        .i_exec_in_ram(ex), .i_ram_emul_on(em), .i_rom_data(rd), .i_init_start(st[4]),
        .i_op_frequency(fq), .i_prog_start(st[5]), .i_target_addr(ta), .i_source_addr(sa),
        .i_src_data(sd), .i_bus_other_master(bm), .i_irq(irq), .i_irq_edge(4'h1),
        .o_flash_key(), .o_prog_sel(psel), .o_erase_sel(esel), .o_dest(), .o_dest_error(derr),
        .o_download_request(dreq), .o_dl_busy(busy), .o_map_routine(), .o_cpu_hold(),
        .o_rom_addr(ra), .o_ram_wr(mw), .o_ram_addr(ma), .o_ram_data(md), .o_init_entry(ie),
        .o_prog_entry(pe), .o_op_done(done), .o_op_result(ores), .o_prog_busy(),
        .o_flash_wr(fw), .o_flash_addr(), .o_flash_data(), .o_src_addr(so), .o_protect(prot),
        .o_irq(oirq));
    fdp_sw_model u_sw (.i_clk(i_clk), .i_rom_addr(ra), .i_src_addr(so), .i_ram_wr(mw),
        .i_ram_addr(ma), .i_ram_data(md), .i_flash_wr(fw), .o_rom_data(rd), .o_src_data(sd),
        .o_result(res), .o_writes(wr));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
        checked++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask
    task automatic end_sim();
        num_errors += expq.size();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge i_clk) st <= m;
        @(posedge i_clk) st <= 6'h00;
    endtask
    task automatic wait_done(input logic b);
        for (i = 0; i < 2000 && done !== 1'b1; i++) begin
            @(posedge i_clk);
            if (i == 20) bm <= b;
        end
        @(posedge i_clk) bm <= 1'b0;
    endtask
    task automatic dl(input logic [7:0] k, input logic [7:0] t, input logic p, input logic e);
        @(posedge i_clk) kd <= k;
        dd <= t;
        ps <= p;
        es <= e;
        pulse(6'h07);
        pulse(6'h08);
        @(negedge i_clk); // Dummy status reads fall here
        chk("busy", {23'h0, k == 8'ha5 && !em && ex}, busy);
        @(posedge i_clk) irq <= 4'h3;
        @(negedge i_clk);
        for (i = 0; i < 200 && busy === 1'b1; i++) @(negedge i_clk);
        @(negedge i_clk);
        chk("held irq", 24'h000003, {20'h0, oirq});
        chk("selects", {21'h0, (k == 8'ha5 && !em && ex) ? 3'h0 : {p, e, 1'b0}},
            {psel, esel, dreq});
        @(posedge i_clk) irq <= 4'h0;
    endtask
    task automatic prog(input logic [7:0] k, input logic [23:0] t, input logic [23:0] s,
            input logic [7:0] e, input logic b);
        @(posedge i_clk) kd <= k;
        ta <= t;
        sa <= s;
        expq.push_back(e);
        pulse(6'h01);
        pulse(6'h20);
        wait_done(b);
    endtask
    // ------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        cyc++;
        if (done === 1'b1 && expq.size() == 0) chk("queue", 1, 0);
        else if (done === 1'b1) chk("result", expq.pop_front(), ores);
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hdf1f8908));
        fqs[4] = 8'(8 + $urandom % 41);
        d = 8'($urandom % 5);
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        dl(8'h00, d, 1, 0);
        dl(8'h5a, d, 1, 0);
        @(posedge i_clk) em <= 1'b1;
        dl(8'ha5, d, 1, 0);
        @(posedge i_clk) em <= 1'b0;
        ex <= 1'b0;
        dl(8'ha5, d, 1, 0);
        @(posedge i_clk) ex <= 1'b1;
        $display("refused requests done");
        dl(8'ha5, d, 1, 0);
        chk("result byte", 8'h00, res);
        chk("prog entry", 24'hff0010 + {10'h0, d[2:0], 11'h0}, pe);
        chk("init entry", 24'hff0020 + {10'h0, d[2:0], 11'h0}, ie);
        dl(8'ha5, 8'h01, 1, 1);
        chk("result byte", 8'h01, res);
        dl(8'ha5, 8'h05, 1, 0);
        chk("dest error", 1, derr);
        chk("result byte", 8'h01, res);
        $display("download tests done");
        foreach (fqs[j]) begin
            @(posedge i_clk) fq <= fqs[j]; // User branch address left zero
            expq.push_back((fqs[j] < 8 || fqs[j] > 48) ? 8'h20 : 8'h00);
            pulse(6'h10);
            wait_done(1'b0);
        end
        $display("init tests done");
        wr0 = wr;
        prog(8'h5a, 24'h000100, 24'hff0000, 8'h00, 0);
        prog(8'h5a, 24'h000100, 24'hff0000, 8'h04, 0);
        prog(8'h5a, 24'h0001c0, 24'hff0000, 8'h01, 0);
        prog(8'h5a, 24'h008000, 24'hff0000, 8'h01, 0);
        prog(8'h5a, 24'h000180, 24'h000100, 8'h02, 0);
        prog(8'h00, 24'h000180, 24'hff0000, 8'h08, 0);
        chk("flash writes", 64, 24'(wr - wr0));
        prog(8'h5a, 24'h000200, 24'hff0000, 8'h10, 1);
        chk("protect", 1, prot);
        prog(8'h5a, 24'h000280, 24'hff0000, 8'h10, 0);
        $display("program tests done");
        end_sim();
    end
endmodule
